//--- afm_amp_model.sv
// power stage and lockout switch model
`timescale 1ns/10ps
module afm_amp_model (
	// clock
	input wire logic i_clock,
	// drive state and requested conditions
	input wire logic i_amp_enable,
	input wire logic [5:0] i_cmd,
	// uv, ov, oi, ot, above continuous, lockout
	output logic [5:0] o_lines
);
	// a dead bridge draws no current, so current faults need the drive on
	always_ff @(posedge i_clock) begin
		o_lines <= i_cmd & {1'b1, i_amp_enable, 1'b1, i_amp_enable, 2'b11};
	end
endmodule // afm_amp_model

//--- afm_checker.sv
// port assertions for the amplifier fault monitor
`timescale 1ns/10ps
module afm_checker
	import afm_pkg::*;
#(parameter int DELAY_UNIT_CYCLES = 4) (
	// clock, reset, inputs
	input wire logic i_clock, i_rst_n, i_under_voltage, i_over_voltage,
	input wire logic i_over_current, i_over_temperature, i_emergency_lockout_input,
	input wire logic i_drive_reenable_cmd, i_report_req, i_thread0_running,
	input wire logic i_handler_present,
	input wire logic [1:0] i_report_sel,
	// outputs
	input wire logic [7:0] o_amplifier_fault_report,
	input wire logic o_report_valid, o_amp_enable, o_lockout_active,
	input wire logic o_amplifier_fault_handler
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	logic [3:0] raw, raw_ff, steady;
	assign raw = {i_over_temperature, i_over_current, i_over_voltage, i_under_voltage};
	assign steady = raw & raw_ff;
	// history cleared in reset so a fault arriving at release is not demanded
	always_ff @(posedge i_clock) raw_ff <= i_rst_n ? raw : 4'h0;
	rep_valid_a: assert property (i_report_req |=> o_report_valid)
		else $error("query not answered");
	quiet_valid_a: assert property (!i_report_req |=> !o_report_valid)
		else $error("answer without query");
	basic_bits_a: assert property (i_report_req && i_report_sel == SEL_BASIC |=>
		(o_amplifier_fault_report & {4'h0, $past(steady)}) == {4'h0, $past(steady)})
		else $error("fault bit missing");
	lock_rep_a: assert property (i_report_req && i_report_sel == SEL_LOCK &&
		o_lockout_active |=> o_amplifier_fault_report == REPORT_LOCKED)
		else $error("lockout not reported");
	lock_set_a: assert property (i_emergency_lockout_input |=> o_lockout_active)
		else $error("lockout not latched");
	amp_off_a: assert property (o_lockout_active |-> !o_amp_enable)
		else $error("drive on in lockout");
	lock_hold_a: assert property (o_lockout_active && !i_drive_reenable_cmd |=>
		o_lockout_active) else $error("lockout dropped");
	handler_go_a: assert property ($rose(o_lockout_active) && i_thread0_running &&
		i_handler_present |=> o_amplifier_fault_handler) else $error("no handler");
	hnd_gate_a: assert property (!i_thread0_running || !i_handler_present |=>
		!o_amplifier_fault_handler) else $error("handler without program");
	cover property ($rose(o_lockout_active));
	cover property ($fell(o_lockout_active));
	cover property (o_amplifier_fault_handler);
	cover property (o_report_valid && o_amplifier_fault_report == REPORT_LOCKED);
endmodule // afm_checker
bind afm_monitor afm_checker #(.DELAY_UNIT_CYCLES(DELAY_UNIT_CYCLES)) chk (.i_clock, .i_rst_n,
	.i_under_voltage, .i_over_voltage, .i_over_current, .i_over_temperature,
	.i_emergency_lockout_input, .i_drive_reenable_cmd, .i_report_req, .i_thread0_running,
	.i_handler_present, .i_report_sel, .o_amplifier_fault_report, .o_report_valid,
	.o_amp_enable, .o_lockout_active, .o_amplifier_fault_handler);

//--- afm_latch.sv
// sticky event flag with set priority over clear
`timescale 1ns/10ps
module afm_latch (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// control
	input wire logic i_set,
	input wire logic i_clear,
	// state
	output logic o_flag
);
	logic flag_ff;
	// set wins so an event in the clear cycle is kept
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			flag_ff <= 1'b0;
		end else if (i_set) begin
			flag_ff <= 1'b1;
		end else if (i_clear) begin
			flag_ff <= 1'b0;
		end
	end
	assign o_flag = flag_ff;
endmodule // afm_latch

//--- afm_monitor.sv
// amplifier fault monitor: detection, report, lockout and handler request
//
// Behaviour
// RULE1: detect over/under-voltage, over-temperature, over-current in brush and brushless modes.
// RULE2: report selector zero returns eight bits flagging under/over-voltage, over-current, temperature.
// RULE3: report selector two shows whether current exceeded continuous setting.
// RULE4: lockout makes selector three report 3 and starts fault handler.
// RULE5: lockout shuts amplifier off in hardware, axis left drive-disabled.
// RULE6: recovery is disable, delay argument 2, re-enable; or a reset.
// RULE7: thread zero with handler label present jumps to handler on fault.
// RULE8: reading the report only reports; it raises no error.
// RULE9: lockout users should set disable-on-fault on all axes.
// RULE10: lockout shutdown stays latched until recovery completes or reset.
`timescale 1ns/10ps
module afm_monitor
#(
	parameter int DELAY_UNIT_CYCLES = afm_pkg::DELAY_UNIT_CYC
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// raw amplifier sensor conditions
	input wire logic i_under_voltage,
	input wire logic i_over_voltage,
	input wire logic i_over_current,
	input wire logic i_over_temperature,
	input wire logic i_above_continuous,
	input wire logic i_brushless_mode,
	// emergency lockout, active high when triggered
	input wire logic i_emergency_lockout_input,
	// operator commands, one-cycle pulses
	input wire logic i_drive_disable_cmd,
	input wire logic i_delay_cmd,
	input wire logic [15:0] i_delay_arg,
	input wire logic i_drive_reenable_cmd,
	// fault report query
	input wire logic i_report_req,
	input wire logic [1:0] i_report_sel,
	// program state
	input wire logic i_thread0_running,
	input wire logic i_handler_present,
	// outputs
	output logic [7:0] o_amplifier_fault_report,
	output logic o_report_valid,
	output logic o_amp_enable,
	output logic o_lockout_active,
	output logic o_amplifier_fault_handler
);
	import afm_pkg::*;

	// ---------------------------------------------
	// fault flags
	// ---------------------------------------------
	logic [3:0] raw_fault;
	logic [3:0] fault_flag;
	logic cont_flag;
	logic lock_flag;
	logic clear_faults;
	logic rec_done;
	logic drive_on_ff;
	logic nxt_drive_on;
	afm_rec_type rec_ff;
	afm_rec_type nxt_rec;
	logic [31:0] wait_cnt_ff;
	logic [31:0] wait_target_ff;
	logic lock_prev_ff;
	logic [3:0] fault_prev_ff;
	logic [7:0] report_ff;
	logic valid_ff;
	logic handler_ff;

	// same detection path regardless of commutation mode
	assign raw_fault[BIT_UNDER_V] = i_under_voltage; // RULE1
	assign raw_fault[BIT_OVER_V] = i_over_voltage; // RULE1
	assign raw_fault[BIT_OVER_I] = i_over_current; // RULE1
	assign raw_fault[BIT_OVER_T] = i_over_temperature; // RULE1

	// sticky flags drop when the drive is re-enabled after recovery
	assign clear_faults = rec_done;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_fault
			afm_latch u_latch (
				.i_clock(i_clock),
				.i_rst_n(i_rst_n),
				.i_set(raw_fault[g]),
				.i_clear(clear_faults),
				.o_flag(fault_flag[g])
			);
		end
	endgenerate

	// continuous current excess, sticky
	afm_latch u_cont (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_set(i_above_continuous),
		.i_clear(clear_faults),
		.o_flag(cont_flag)
	);

	// lockout held until recovery even if input releases
	afm_latch u_lock (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_set(i_emergency_lockout_input), // RULE10
		.i_clear(rec_done), // RULE10
		.o_flag(lock_flag)
	);

	// ---------------------------------------------
	// recovery sequence
	// ---------------------------------------------
	// re-enable only completes after disable then a long enough delay
	always_comb begin
		nxt_rec = rec_ff;
		rec_done = 1'b0;
		case (rec_ff)
			REC_IDLE: begin
				if (i_drive_disable_cmd) nxt_rec = REC_DISABLED; // RULE6
			end
			REC_DISABLED: begin
				if (i_delay_cmd && i_delay_arg >= 16'(DELAY_ARG_MIN)
						&& wait_cnt_ff == 32'h0) begin
					nxt_rec = REC_WAITED; // RULE6
				end
			end
			REC_WAITED: begin
				if (i_drive_reenable_cmd && wait_cnt_ff == 32'h0) begin
					rec_done = 1'b1; // RULE6
					nxt_rec = REC_IDLE;
				end else if (i_drive_disable_cmd) begin
					nxt_rec = REC_DISABLED;
				end
			end
			default: nxt_rec = REC_IDLE;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rec_ff <= REC_IDLE;
		end else begin
			rec_ff <= nxt_rec;
		end
	end

	// delay counter loads on a delay command in REC_DISABLED, counts down in cycles
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			wait_cnt_ff <= 32'h0;
		end else if (i_delay_cmd && rec_ff == REC_DISABLED) begin
			wait_cnt_ff <= 32'(i_delay_arg) * 32'(DELAY_UNIT_CYCLES);
		end else if (wait_cnt_ff != 32'h0) begin
			wait_cnt_ff <= wait_cnt_ff - 32'h1;
		end
	end

	// ---------------------------------------------
	// amplifier enable
	// ---------------------------------------------
	// lockout overrides any software enable at the hardware level
	always_comb begin
		nxt_drive_on = drive_on_ff;
		if (i_drive_disable_cmd) nxt_drive_on = 1'b0;
		else if (i_drive_reenable_cmd && (!lock_flag || rec_done)) nxt_drive_on = 1'b1;
		if (i_emergency_lockout_input) nxt_drive_on = 1'b0; // RULE5
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			drive_on_ff <= 1'b0;
		end else begin
			drive_on_ff <= nxt_drive_on;
		end
	end

	assign o_amp_enable = drive_on_ff && !lock_flag; // RULE5
	assign o_lockout_active = lock_flag;

	// ---------------------------------------------
	// fault report query
	// ---------------------------------------------
	// query only reads flags; nothing here feeds the handler
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			report_ff <= REPORT_CLEAR;
			valid_ff <= 1'b0;
		end else begin
			valid_ff <= i_report_req; // RULE8
			if (i_report_req) begin
				case (i_report_sel)
					SEL_BASIC: report_ff <= {4'h0, fault_flag}; // RULE2
					SEL_CONT: report_ff <= cont_flag ? REPORT_CONT : REPORT_CLEAR; // RULE3
					SEL_LOCK: report_ff <= lock_flag ? REPORT_LOCKED : REPORT_CLEAR; // RULE4
					default: report_ff <= REPORT_CLEAR;
				endcase
			end
		end
	end
	assign o_amplifier_fault_report = report_ff;
	assign o_report_valid = valid_ff;

	// ---------------------------------------------
	// fault handler request
	// ---------------------------------------------
	// one pulse for each cycle in which a fault or the lockout newly latches, so a lockout
	// still reaches the handler even while an older fault is standing
	logic any_fault;
	assign any_fault = |(fault_flag & ~fault_prev_ff) || (lock_flag && !lock_prev_ff);

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			fault_prev_ff <= 4'h0;
			lock_prev_ff <= 1'b0;
			handler_ff <= 1'b0;
		end else begin
			fault_prev_ff <= fault_flag;
			lock_prev_ff <= lock_flag;
			handler_ff <= any_fault
				&& i_thread0_running && i_handler_present; // RULE7 RULE4
		end
	end
	assign o_amplifier_fault_handler = handler_ff;

	// brushless mode kept for visibility only, detection does not depend on it
	logic unused_ok;
	assign unused_ok = i_brushless_mode;
endmodule // afm_monitor

//--- afm_monitor_tb.sv
// self-checking bench for the amplifier fault monitor
`timescale 1ns/10ps
module afm_monitor_tb;
	import afm_pkg::*;
	logic i_clock = 0, i_rst_n = 0, dis = 0, dly = 0, ren = 0, req = 0, bl = 0;
	logic thr = 1, hp = 1;
	int hcount = 0, h0 = 0;
	logic [1:0] sel = 0;
	logic [15:0] arg = 0;
	logic [5:0] cmd = 0, lines;
	logic [7:0] rep, q[$];
	logic val, amp, lock, hnd;
	logic [31:0] seed = 32'h61a3ce81;
	int failures = 0, comparisons = 0;
	initial forever #5 i_clock = ~i_clock;
	afm_amp_model amp_m (.i_clock, .i_amp_enable(amp), .i_cmd(cmd), .o_lines(lines));
	afm_monitor #(.DELAY_UNIT_CYCLES(4)) DUT (.i_clock, .i_rst_n,
		.i_under_voltage(lines[0]), .i_over_voltage(lines[1]), .i_over_current(lines[2]),
		.i_over_temperature(lines[3]), .i_above_continuous(lines[4]),
		.i_brushless_mode(bl), .i_emergency_lockout_input(lines[5]),
		.i_drive_disable_cmd(dis), .i_delay_cmd(dly), .i_delay_arg(arg),
		.i_drive_reenable_cmd(ren), .i_report_req(req), .i_report_sel(sel),
		.i_thread0_running(thr), .i_handler_present(hp),
		.o_amplifier_fault_report(rep), .o_report_valid(val), .o_amp_enable(amp),
		.o_lockout_active(lock), .o_amplifier_fault_handler(hnd));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("wrong value at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// inputs always move 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic query(input logic [1:0] s, input logic [7:0] e);
		tick(1);
		req = 1;
		sel = s;
		q.push_back(e);
		tick(1);
		req = 0;
		tick(2);
	endtask
	// disable, delay of 2 units, then re-enable once the delay has run out
	task automatic recover;
		dis = 1;
		tick(1);
		dis = 0;
		dly = 1;
		arg = 16'h2;
		tick(1);
		dly = 0;
		tick(12);
		ren = 1;
		tick(1);
		ren = 0;
		tick(2);
	endtask
	// answers are taken at the falling edge, after registers have settled
	always @(negedge i_clock) if (val === 1'b1) begin
		if (q.size() == 0) chk(rep, 8'hxx);
		else chk(rep, q.pop_front());
	end
	// handler pulses last one cycle, so count them where they stand
	always @(negedge i_clock) if (hnd === 1'b1) hcount++;
	initial begin
		#20000;
		failures++;
		tally_and_finish;
	end
	initial begin
		tick(3);
		i_rst_n = 1;
		for (int s = 0; s < 4; s++) query(s[1:0], REPORT_CLEAR);
		recover;
		chk({7'h0, amp}, 8'h01);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			bl = seed[4];
			thr = seed[6];
			hp = seed[7];
			h0 = hcount;
			cmd = {1'b0, seed[5], seed[3:0]};
			tick(3);
			query(SEL_BASIC, {4'h0, seed[3:0]});
			chk(8'(hcount - h0), {7'h0, (|seed[3:0]) && seed[6] && seed[7]});
			query(SEL_CONT, {7'h0, seed[5]});
			query(SEL_BASIC, {4'h0, seed[3:0]});
			cmd = 0;
			tick(2);
			recover;
			query(SEL_BASIC, REPORT_CLEAR);
		end
		thr = 1;
		hp = 1;
		h0 = hcount;
		cmd[5] = 1;
		tick(2);
		chk({6'h0, lock, amp}, 8'h02);
		cmd[5] = 0;
		tick(2);
		query(SEL_LOCK, REPORT_LOCKED);
		chk(8'(hcount - h0), 8'h01);
		ren = 1;
		tick(1);
		ren = 0;
		tick(2);
		chk({7'h0, lock}, 8'h01);
		recover;
		chk({6'h0, lock, amp}, 8'h01);
		query(SEL_LOCK, REPORT_CLEAR);
		// second lockout, this time left by a mid-run reset
		cmd[5] = 1;
		tick(2);
		cmd[5] = 0;
		tick(2);
		i_rst_n = 0;
		tick(2);
		i_rst_n = 1;
		tick(1);
		chk({6'h0, lock, amp}, 8'h00);
		query(SEL_LOCK, REPORT_CLEAR);
		tally_and_finish;
	end
endmodule // afm_monitor_tb

//--- afm_pkg.sv
// package of constants for the amplifier fault monitor
package afm_pkg;
	// fault report selectors
	localparam logic [1:0] SEL_BASIC = 2'h0;
	localparam logic [1:0] SEL_CONT = 2'h2;
	localparam logic [1:0] SEL_LOCK = 2'h3;
	// bit positions in the basic fault report
	localparam int BIT_UNDER_V = 0;
	localparam int BIT_OVER_V = 1;
	localparam int BIT_OVER_I = 2;
	localparam int BIT_OVER_T = 3;
	// answer values
	localparam logic [7:0] REPORT_LOCKED = 8'h03;
	localparam logic [7:0] REPORT_CLEAR = 8'h00;
	localparam logic [7:0] REPORT_CONT = 8'h01;
	// recovery delay argument and its time unit (ms)
	localparam int DELAY_ARG_MIN = 2;
	localparam int DELAY_UNIT_NS = 1000000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int DELAY_UNIT_CYC = DELAY_UNIT_NS / CLK_PERIOD_NS;
	// recovery sequence states
	typedef enum logic [2:0] {
		REC_IDLE = 3'h1,
		REC_DISABLED = 3'h2,
		REC_WAITED = 3'h4
	} afm_rec_type;
endpackage
